// [design/caf_defs.svh]
// Register offsets, field positions and reset values of the acceptance filter
`ifndef CAF_DEFS_SVH
`define CAF_DEFS_SVH
`define CAF_ADDR_W 4
`define CAF_ADDR_VALUE 4'h0
`define CAF_ADDR_CTRL 4'h4
`define CAF_ADDR_STATUS 4'h8
`define CAF_SID_HI 31
`define CAF_SID_LO 21
`define CAF_RSV_HI_BIT 20
`define CAF_FRAME_FORMAT_SELECT_BIT 19
`define CAF_RSV_LO_BIT 18
`define CAF_EID_HI 17
`define CAF_EID_LO 0
`define CAF_VALUE_WMASK 32'hFFEBFFFF
`define CAF_VALUE_RESET 32'h00000000
`define CAF_CTRL_EN_BIT 0
`define CAF_CTRL_MASK_CHOICE_HI 2
`define CAF_CTRL_MASK_CHOICE_LO 1
`define CAF_CTRL_DEST_HI 7
`define CAF_CTRL_DEST_LO 3
`define CAF_CTRL_RESET 8'h00
`define CAF_DEST_RSV_BIT 4
`define CAF_ID_W 29
`endif

// [design/caf_pkg.sv]
// Types shared by the acceptance filter modules
package caf_pkg;
  typedef logic [10:0] caf_sid_t;
  typedef logic [17:0] caf_eid_t;
  typedef logic [28:0] caf_ident_t;
  typedef logic [1:0] caf_mask_sel_t;
  typedef logic [4:0] caf_dest_t;
endpackage : caf_pkg

// [design/caf_id_compare.sv]
// Per-bit identifier comparison against stored pattern under a mask
`timescale 1ns/1ps
`include "caf_defs.svh"
module caf_id_compare (
  input wire caf_pkg::caf_ident_t pattern,
  input wire caf_pkg::caf_ident_t ident,
  input wire caf_pkg::caf_ident_t mask,
  input wire logic use_ext,
  output logic all_equal
);
  wire caf_pkg::caf_ident_t bit_ok;
  genvar i;
  generate
    for (i = 0; i < `CAF_ID_W; i = i + 1)
    begin : g_bit
      // Extended bits are don't-care on standard frames
      if (i < 18)
      begin : g_eid
        assign bit_ok[i] = ~use_ext | ~mask[i] | (pattern[i] == ident[i]);
      end
      else
      begin : g_sid
        assign bit_ok[i] = ~mask[i] | (pattern[i] == ident[i]);
      end
    end
  endgenerate
  assign all_equal = &bit_ok;
endmodule : caf_id_compare

// [design/caf_filter.sv]
// One CAN receive acceptance filter: pattern register, control and match logic
// What this block does
// - Stored standard identifier bits must equal received ones
// - Format bit one accepts extended frames only
// - Format bit zero accepts standard frames only
// - Stored extended identifier bits must equal received ones on extended frames only
// - Pattern writes ignored while filter enabled
// - Bits twenty and eighteen read zero
// - Enable bit turns filter on or off
// - Mask choice selects one of four masks
// - Destination codes 0-15 route, upper codes reserved
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "caf_defs.svh"
module caf_filter (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [`CAF_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic id_valid,
  input wire caf_pkg::caf_sid_t id_std,
  input wire caf_pkg::caf_eid_t id_ext,
  input wire logic id_is_ext,
  input wire caf_pkg::caf_ident_t applied_mask,
  output logic filter_enable_bit,
  output caf_pkg::caf_mask_sel_t mask_choice,
  output caf_pkg::caf_dest_t destination_buffer_choice,
  output logic match_valid,
  output logic match_hit,
  output caf_pkg::caf_dest_t match_dest
);
  logic [31:0] filter_value;
  logic [7:0] filter_ctrl;
  logic last_hit;
  logic dropped_reserved;
  logic [7:0] hit_count;

  wire sel_value = (reg_addr == `CAF_ADDR_VALUE);
  wire sel_ctrl = (reg_addr == `CAF_ADDR_CTRL);
  wire sel_status = (reg_addr == `CAF_ADDR_STATUS);

  wire caf_pkg::caf_sid_t standard_identifier_pattern =
    filter_value[`CAF_SID_HI:`CAF_SID_LO];
  wire caf_pkg::caf_eid_t extended_identifier_pattern =
    filter_value[`CAF_EID_HI:`CAF_EID_LO];
  wire frame_format_select = filter_value[`CAF_FRAME_FORMAT_SELECT_BIT];

  assign filter_enable_bit = filter_ctrl[`CAF_CTRL_EN_BIT];
  assign mask_choice = filter_ctrl[`CAF_CTRL_MASK_CHOICE_HI:`CAF_CTRL_MASK_CHOICE_LO];
  assign destination_buffer_choice = filter_ctrl[`CAF_CTRL_DEST_HI:`CAF_CTRL_DEST_LO];

  // Writes to the pattern are dropped while the filter is live
  wire value_wr_ok = reg_wr & sel_value & ~filter_enable_bit;
  // Unimplemented bits never store, so they always read back zero
  wire [31:0] next_filter_value = reg_wdata & `CAF_VALUE_WMASK;
  wire ctrl_wr = reg_wr & sel_ctrl;

  wire [31:0] status_word = {22'h00000, hit_count, dropped_reserved, last_hit};
  wire [31:0] next_rdata = sel_value ? filter_value :
                           sel_ctrl ? {24'h000000, filter_ctrl} :
                           sel_status ? status_word : 32'h00000000;

  wire caf_pkg::caf_ident_t pattern_word =
    {standard_identifier_pattern, extended_identifier_pattern};
  wire caf_pkg::caf_ident_t ident_word = {id_std, id_ext};
  logic bits_equal;

  caf_id_compare u_compare (
    .pattern(pattern_word),
    .ident(ident_word),
    .mask(applied_mask),
    .use_ext(id_is_ext),
    .all_equal(bits_equal)
  );

  wire format_ok = (frame_format_select == id_is_ext);
  wire next_hit = filter_enable_bit & format_ok & bits_equal;
  // Reserved destinations have no buffer, so such a hit is not routed
  wire dest_reserved = destination_buffer_choice[`CAF_DEST_RSV_BIT];
  wire next_match_valid = id_valid & next_hit & ~dest_reserved;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      filter_value <= `CAF_VALUE_RESET;
      filter_ctrl <= `CAF_CTRL_RESET;
    end
    else
    begin
      if (value_wr_ok)
      begin
        filter_value <= next_filter_value;
      end
      if (ctrl_wr)
      begin
        filter_ctrl <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      match_valid <= 1'b0;
      match_hit <= 1'b0;
      match_dest <= 5'h00;
    end
    else
    begin
      match_valid <= next_match_valid;
      match_hit <= id_valid & next_hit;
      match_dest <= destination_buffer_choice;
    end
  end

  // Status: last result, sticky reserved-drop flag, wrapping hit counter
  wire status_clr = reg_wr & sel_status;
  wire drop_event = id_valid & next_hit & dest_reserved;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      last_hit <= 1'b0;
      dropped_reserved <= 1'b0;
      hit_count <= 8'h00;
    end
    else
    begin
      if (id_valid)
      begin
        last_hit <= next_hit;
      end
      // Set wins over a clear in the same cycle
      if (drop_event)
      begin
        dropped_reserved <= 1'b1;
      end
      else if (status_clr)
      begin
        dropped_reserved <= 1'b0;
      end
      if (next_match_valid)
      begin
        hit_count <= hit_count + 8'h01;
      end
    end
  end

  write_block_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reg_wr && sel_value && filter_enable_bit) |=> $stable(filter_value))
    else $error("pattern changed while filter enabled");

  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reg_rd && sel_value) |=> (reg_rdata[20] == 1'b0 && reg_rdata[18] == 1'b0))
    else $error("unimplemented bit read as one");

  disabled_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (id_valid && !filter_enable_bit) |=> (!match_hit && !match_valid))
    else $error("disabled filter matched");

  ext_only_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (id_valid && frame_format_select && !id_is_ext) |=> !match_hit)
    else $error("standard frame matched extended filter");

  std_only_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (id_valid && !frame_format_select && id_is_ext) |=> !match_hit)
    else $error("extended frame matched standard filter");

  sid_mismatch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (id_valid && ((id_std ^ standard_identifier_pattern) & applied_mask[28:18]) != 11'h000)
    |=> !match_hit)
    else $error("standard identifier mismatch accepted");

  eid_mismatch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (id_valid && id_is_ext
     && ((id_ext ^ extended_identifier_pattern) & applied_mask[17:0]) != 18'h00000)
    |=> !match_hit)
    else $error("extended identifier mismatch accepted");

  mask_route_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl_wr |=> (mask_choice == $past(reg_wdata[2:1])))
    else $error("mask choice not taken from control");

  dest_legal_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    match_valid |-> (match_dest[4] == 1'b0 && match_hit))
    else $error("match routed to reserved buffer");

  full_match_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (id_valid && filter_enable_bit && (frame_format_select == id_is_ext)
     && ((id_std ^ standard_identifier_pattern) & applied_mask[28:18]) == 11'h000
     && (!id_is_ext
         || ((id_ext ^ extended_identifier_pattern) & applied_mask[17:0]) == 18'h00000))
    |=> match_hit)
    else $error("matching identifier rejected");

  std_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (id_valid && !id_is_ext && filter_enable_bit && !frame_format_select
     && ((id_std ^ standard_identifier_pattern) & applied_mask[28:18]) == 11'h000)
    |=> match_hit)
    else $error("standard frame with matching identifier rejected");

  reset_clear_a: assert property (@(posedge sys_clk)
    !rst_b |=> (filter_value == `CAF_VALUE_RESET && filter_ctrl == `CAF_CTRL_RESET
    && reg_rdata == 32'h00000000 && !match_valid && !match_hit))
    else $error("state not cleared by reset");

  value_store_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    value_wr_ok
    |=> (filter_value == ($past(reg_wdata) & `CAF_VALUE_WMASK)))
    else $error("pattern write not stored");

  value_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !value_wr_ok |=> $stable(filter_value))
    else $error("pattern changed without accepted write");

  reserved_store_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (filter_value[`CAF_RSV_HI_BIT] == 1'b0 && filter_value[`CAF_RSV_LO_BIT] == 1'b0))
    else $error("unimplemented bit stored");

  ctrl_store_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl_wr |=> (filter_ctrl == $past(reg_wdata[7:0])
    && filter_enable_bit == $past(reg_wdata[`CAF_CTRL_EN_BIT])))
    else $error("control write not stored");

  ctrl_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !ctrl_wr |=> $stable(filter_ctrl))
    else $error("control changed without write");

  // Read data is zero outside its cycle, so an outer bus may OR slaves together
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !reg_rd |=> (reg_rdata == 32'h00000000))
    else $error("read data outside read cycle");

  value_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reg_rd && sel_value) |=> (reg_rdata == $past(filter_value)))
    else $error("pattern read back wrong");

  ctrl_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reg_rd && sel_ctrl) |=> (reg_rdata == {24'h000000, $past(filter_ctrl)}))
    else $error("control read back wrong");

  status_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reg_rd && sel_status)
    |=> (reg_rdata == {22'h00000, $past(hit_count), $past(dropped_reserved),
    $past(last_hit)}))
    else $error("status read back wrong");

  unmapped_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reg_rd && !sel_value && !sel_ctrl && !sel_status)
    |=> (reg_rdata == 32'h00000000))
    else $error("unmapped address read nonzero");

  idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !id_valid |=> (!match_hit && !match_valid))
    else $error("match without identifier");

  dest_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    id_valid |=> (match_dest == $past(destination_buffer_choice)))
    else $error("destination not captured");

  route_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (id_valid && next_hit && !dest_reserved) |=> (match_valid && match_hit))
    else $error("legal destination not routed");

  // A drop in the same cycle as a clear must survive
  reserved_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (id_valid && next_hit && dest_reserved)
    |=> (match_hit && !match_valid && dropped_reserved))
    else $error("reserved destination routed");

  drop_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (status_clr && !drop_event) |=> !dropped_reserved)
    else $error("reserved-drop flag not cleared");

  drop_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (dropped_reserved && !status_clr) |=> dropped_reserved)
    else $error("reserved-drop flag lost");

  last_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    id_valid |=> (last_hit == match_hit))
    else $error("last result not recorded");

  // Counter wraps silently; software must sample it often enough
  count_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    next_match_valid |=> (hit_count == $past(hit_count) + 8'h01))
    else $error("routed hit not counted");

  count_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !next_match_valid |=> $stable(hit_count))
    else $error("hit count moved without routed hit");
endmodule : caf_filter

// [tb/caf_id_source.sv]
// Model of the protocol engine that hands received identifiers to the filter
`timescale 1ns/1ps
module caf_id_source (
  input wire logic sys_clk,
  output logic id_valid,
  output caf_pkg::caf_sid_t id_std,
  output caf_pkg::caf_eid_t id_ext,
  output logic id_is_ext
);
  initial
  begin
    id_valid = 1'b0;
    id_is_ext = 1'b0;
    id_std = 11'h000;
    id_ext = 18'h00000;
  end
  // Fields go inverse after the pulse, so a stale value never passes for a match
  task automatic send(input logic ext, input caf_pkg::caf_sid_t s, input caf_pkg::caf_eid_t e);
    @(posedge sys_clk);
    id_valid <= 1'b1;
    id_is_ext <= ext;
    id_std <= s;
    id_ext <= e;
    @(posedge sys_clk);
    id_valid <= 1'b0;
    id_is_ext <= ~ext;
    id_std <= ~s;
    id_ext <= ~e;
  endtask : send
endmodule : caf_id_source

// [tb/tb_top.sv]
// Self-checking testbench for one acceptance filter
`timescale 1ns/1ps
`include "caf_defs.svh"
module tb_top;
  localparam logic [10:0] PS = 11'h5A3;
  localparam logic [17:0] PE = 18'h2C3A5;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic id_valid, id_is_ext, filter_enable_bit, match_valid, match_hit;
  caf_pkg::caf_sid_t id_std;
  caf_pkg::caf_eid_t id_ext;
  caf_pkg::caf_ident_t mask_tab [4];
  caf_pkg::caf_ident_t applied_mask;
  caf_pkg::caf_mask_sel_t mask_choice;
  caf_pkg::caf_dest_t destination_buffer_choice, match_dest;
  logic [4:0] cur_dest = 5'h00;
  int fails = 0;
  int checks = 0;
  // Mask bank lives outside the filter and follows its choice output
  assign applied_mask = mask_tab[mask_choice];
  always #20 sys_clk = ~sys_clk;
  caf_filter caf_filter_i (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .id_valid(id_valid), .id_std(id_std), .id_ext(id_ext), .id_is_ext(id_is_ext),
    .applied_mask(applied_mask), .filter_enable_bit(filter_enable_bit),
    .mask_choice(mask_choice), .destination_buffer_choice(destination_buffer_choice),
    .match_valid(match_valid), .match_hit(match_hit), .match_dest(match_dest));
  caf_id_source caf_id_source_i (.sys_clk(sys_clk), .id_valid(id_valid), .id_std(id_std),
    .id_ext(id_ext), .id_is_ext(id_is_ext));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", exp, reg_rdata);
    @(posedge sys_clk);
    #1;
    check("reg_rdata idle", 32'h00000000, reg_rdata);
  endtask : rd_chk
  task automatic set_ctrl(input logic en, input logic [1:0] m, input logic [4:0] d);
    cur_dest = d;
    wr(`CAF_ADDR_CTRL, {24'h0, d, m, en});
    #1;
    check("control outputs", {24'h0, d, m, en},
      {24'h0, destination_buffer_choice, mask_choice, filter_enable_bit});
  endtask : set_ctrl
  task automatic id_chk(input logic x, input logic [10:0] s, input logic [17:0] e,
    input logic hit, input logic vld);
    caf_id_source_i.send(x, s, e);
    #1;
    check("match_hit", {31'h0, hit}, {31'h0, match_hit});
    check("match_valid", {31'h0, vld}, {31'h0, match_valid});
    if (hit)
      check("match_dest", {27'h0, cur_dest}, {27'h0, match_dest});
  endtask : id_chk
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic t_regs;
    rd_chk(`CAF_ADDR_VALUE, 32'h00000000);
    rd_chk(4'hC, 32'h00000000);
    wr(`CAF_ADDR_VALUE, 32'hFFFFFFFF);
    rd_chk(`CAF_ADDR_VALUE, 32'hFFEBFFFF);
    $display("test regs done");
  endtask : t_regs
  task automatic t_formats;
    wr(`CAF_ADDR_VALUE, {PS, 3'b010, PE});
    set_ctrl(1'b1, 2'b00, 5'h05);
    id_chk(1'b1, PS, PE, 1'b1, 1'b1);
    id_chk(1'b0, PS, PE, 1'b0, 1'b0);
    id_chk(1'b1, PS ^ 11'h400, PE, 1'b0, 1'b0);
    id_chk(1'b1, PS, PE ^ 18'h20000, 1'b0, 1'b0);
    set_ctrl(1'b0, 2'b00, 5'h05);
    id_chk(1'b1, PS, PE, 1'b0, 1'b0);
    wr(`CAF_ADDR_VALUE, {PS, 3'b000, PE});
    set_ctrl(1'b1, 2'b00, 5'h05);
    id_chk(1'b0, PS, ~PE, 1'b1, 1'b1);
    id_chk(1'b1, PS, PE, 1'b0, 1'b0);
    wr(`CAF_ADDR_VALUE, {~PS, 3'b010, ~PE});
    rd_chk(`CAF_ADDR_VALUE, {PS, 3'b000, PE});
    id_chk(1'b0, PS, PE, 1'b1, 1'b1);
    $display("test formats done");
  endtask : t_formats
  task automatic t_masks;
    logic [3:0] sid_hit;
    logic [3:0] eid_hit;
    sid_hit = 4'hA;
    eid_hit = 4'hC;
    set_ctrl(1'b0, 2'b00, 5'h05);
    wr(`CAF_ADDR_VALUE, {PS, 3'b010, PE});
    rd_chk(`CAF_ADDR_VALUE, {PS, 3'b010, PE});
    for (int m = 0; m < 4; m++)
    begin
      set_ctrl(1'b1, m[1:0], 5'h05);
      id_chk(1'b1, PS ^ 11'h001, PE, sid_hit[m], sid_hit[m]);
      id_chk(1'b1, PS, PE ^ 18'h00001, eid_hit[m], eid_hit[m]);
    end
    $display("test masks done");
  endtask : t_masks
  task automatic t_dest;
    set_ctrl(1'b1, 2'b00, 5'h0F);
    id_chk(1'b1, PS, PE, 1'b1, 1'b1);
    set_ctrl(1'b1, 2'b00, 5'h10);
    id_chk(1'b1, PS, PE, 1'b1, 1'b0);
    set_ctrl(1'b1, 2'b00, 5'h1F);
    id_chk(1'b1, PS, PE, 1'b1, 1'b0);
    $display("test dest done");
  endtask : t_dest
  task automatic t_status;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd_chk(`CAF_ADDR_VALUE, 32'h00000000);
    rd_chk(`CAF_ADDR_CTRL, 32'h00000000);
    rd_chk(`CAF_ADDR_STATUS, 32'h00000000);
    wr(`CAF_ADDR_VALUE, {PS, 3'b010, PE});
    set_ctrl(1'b1, 2'b00, 5'h05);
    rd_chk(`CAF_ADDR_CTRL, 32'h00000029);
    id_chk(1'b1, PS, PE, 1'b1, 1'b1);
    rd_chk(`CAF_ADDR_STATUS, 32'h00000005);
    set_ctrl(1'b1, 2'b00, 5'h10);
    id_chk(1'b1, PS, PE, 1'b1, 1'b0);
    rd_chk(`CAF_ADDR_STATUS, 32'h00000007);
    id_chk(1'b0, PS, PE, 1'b0, 1'b0);
    rd_chk(`CAF_ADDR_STATUS, 32'h00000006);
    wr(`CAF_ADDR_STATUS, 32'h00000000);
    rd_chk(`CAF_ADDR_STATUS, 32'h00000004);
    $display("test status done");
  endtask : t_status
  initial
  begin
    mask_tab[0] = 29'h1FFFFFFF;
    mask_tab[1] = 29'h1FFBFFFF;
    mask_tab[2] = 29'h1FFFFFFE;
    mask_tab[3] = 29'h00000000;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_formats();
    t_masks();
    t_dest();
    t_status();
    print_verdict();
  end
  // Whole run is some one hundred forty cycles
  initial
  begin
    #(40 * 3000);
    fails++;
    print_verdict();
  end
endmodule : tb_top
